// [srpd_map.svh]
// Purpose: offsets, fields, reset values and counts for the serdes control block
// Assumes: one system clock stands in for the selected reference clock
// Notes:   definitions only
`ifndef SRPD_MAP_SVH
`define SRPD_MAP_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SRPD_CFG_OFFSET      8'h07
`define SRPD_CFG_RESET       8'h20
`define SRPD_CFG_REFSEL_LO   0
`define SRPD_CFG_PGEN_BIT    2
`define SRPD_CFG_PCLR_BIT    3
`define SRPD_CFG_SLOOP_BIT   4
`define SRPD_CFG_ALTF_BIT    5
`define SRPD_CFG_PLOOP_BIT   6
`define SRPD_CFG_LTIME_BIT   7

// ----------------------------------------------------------------
// data path
// ----------------------------------------------------------------
`define SRPD_WORD_W          16
`define SRPD_PRBS_LEN        23
`define SRPD_PRBS_TAP        18
`define SRPD_PRBS_SEED       23'h7FFFFF
`define SRPD_TX_LAT          5'h12
`define SRPD_SYNC_GOOD       4'h8
`define SRPD_BUF_DEPTH       2

`endif

// [srpd_pkg.sv]
// Purpose: shared types for the serdes control block
// Assumes: nothing
// Notes:   constants live in srpd_map.svh
package srpd_pkg;
    typedef enum logic [1:0] {
        SRPD_CHK_HUNT,
        SRPD_CHK_LOCK,
        SRPD_CHK_IDLE
    } srpd_chk_t;
    typedef logic [15:0] srpd_word_t;
endpackage : srpd_pkg

// [srpd_buf.sv]
// Purpose: two-entry valid/ready buffer on the receive word path
// Assumes: synchronous active-high reset
// Notes:   full and empty are exact; nothing is dropped under stall
`timescale 1ns/1ns
`default_nettype none
`include "srpd_map.svh"
module srpd_buf
    import srpd_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       in_valid_in,
    output logic            in_ready_out,
    input  wire srpd_word_t in_data_in,
    output logic            out_valid_out,
    input  wire logic       out_ready_in,
    output srpd_word_t      out_data_out
);
    srpd_word_t mem [`SRPD_BUF_DEPTH];
    logic       wr_ptr;
    logic       rd_ptr;
    logic [1:0] count;
    logic       push;
    logic       pop;

    assign push          = in_valid_in && (count != 2'h2);
    assign pop           = out_ready_in && (count != 2'h0);
    assign in_ready_out  = (count != 2'h2);
    assign out_valid_out = (count != 2'h0);
    assign out_data_out  = mem[rd_ptr];

    always_ff @(posedge sys_clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= 2'(count + {1'b0, push} - {1'b0, pop});
        end
    end
endmodule : srpd_buf
`default_nettype wire

// [srpd_top.sv]
// Purpose: control side of a 16-bit serdes: mode mux, ref select, prbs, loopback
// Assumes: sys_clk_in is the selected reference, one serial bit per cycle; serial lanes are bit-serial ports
// Notes:   register port is a plain parallel write/read of the configuration register
`timescale 1ns/1ns
`default_nettype none
`include "srpd_map.svh"

// Overview of operation
// - control_source_select low or open gives hardware mode from strap pins.
// - control_source_select high takes configuration from the configuration register.
// - both modes share the other controls; half-rate reference and loop timing exist in host mode only.
// - tx serializes 16-bit words msb first; rx deserializes back to words.
// - ref select upper bit picks tx reference, lower bit rx reference.
// - host mode only, alt bit d5 low selects half-rate references.
// - tx parallel to serial latency is 18 to 20 reference cycles.
// - fec reference on tx means fec line rate indication.
// - pattern_gen_enable replaces tx data with a 2^23-1 prbs.
// - pattern_gen_enable also enables the rx prbs checker.
// - fault flag is 1 whenever the checker is not synchronized.
// - pulsing pattern_fault_clear low clears the flag and restarts the search.
// - flag goes low once the checker sees the correct sequence.
// - serial remote loopback is forced off while prbs runs.
// - recovered serial data forms 16-bit parallel words on rx output.
// - at start, loss of signal or loss of lock use local reference.
// - host mode lets parallel remote loopback use de-jittered loop timing.
module srpd_top
    import srpd_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       control_source_select_in,
    input  wire logic       reg_wr_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    input  wire logic [1:0] strap_ref_rate_select_in,
    input  wire logic       strap_pattern_gen_enable_in,
    input  wire logic       strap_pattern_fault_clear_in,
    input  wire logic       strap_serial_remote_loopback_in,
    input  wire logic       strap_parallel_remote_loopback_in,
    input  wire logic       signal_lost_in,
    input  wire logic       lock_lost_in,
    input  wire srpd_word_t tx_parallel_in,
    output logic            tx_serial_out,
    input  wire logic       rx_serial_in,
    output srpd_word_t      rx_parallel_out,
    output logic            rx_parallel_valid_out,
    input  wire logic       rx_parallel_ready_in,
    output logic            tx_ref_fec_out,
    output logic            rx_ref_fec_out,
    output logic            ref_half_rate_out,
    output logic            rx_ref_local_out,
    output logic            loop_timing_out,
    output logic            pattern_fault_flag_out
);
    // ----------------------------------------------------------------
    // configuration register and control mux
    // ----------------------------------------------------------------
    logic [7:0] configuration_control;
    logic       host_mode;
    logic [1:0] ref_rate_select;
    logic       pattern_gen_enable;
    logic       pattern_fault_clear;
    logic       serial_remote_loopback;
    logic       parallel_remote_loopback;
    logic       alt_ref_freq_select;
    logic       clear_prev;
    logic       clear_pulse;

    function automatic logic pick(input logic host, input logic reg_bit, input logic pin);
        pick = host ? reg_bit : pin;
    endfunction : pick

    assign host_mode = control_source_select_in;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            configuration_control <= `SRPD_CFG_RESET;
        end else if (reg_wr_in && host_mode && reg_addr_in == `SRPD_CFG_OFFSET) begin
            configuration_control <= reg_wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_addr_in == `SRPD_CFG_OFFSET) begin
            reg_rdata_out <= configuration_control;
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // one mux per control bit; loop timing and the alternate reference bit read host_mode and their register bits directly
    assign ref_rate_select[0] = pick(host_mode,
        configuration_control[`SRPD_CFG_REFSEL_LO], strap_ref_rate_select_in[0]);
    assign ref_rate_select[1] = pick(host_mode,
        configuration_control[`SRPD_CFG_REFSEL_LO+1], strap_ref_rate_select_in[1]);
    assign pattern_gen_enable = pick(host_mode,
        configuration_control[`SRPD_CFG_PGEN_BIT], strap_pattern_gen_enable_in);
    assign pattern_fault_clear = pick(host_mode,
        configuration_control[`SRPD_CFG_PCLR_BIT], strap_pattern_fault_clear_in);
    assign serial_remote_loopback = pick(host_mode,
        configuration_control[`SRPD_CFG_SLOOP_BIT], strap_serial_remote_loopback_in);
    assign parallel_remote_loopback = pick(host_mode,
        configuration_control[`SRPD_CFG_PLOOP_BIT], strap_parallel_remote_loopback_in);
    // hardware mode has no alternate reference: always full rate
    assign alt_ref_freq_select = host_mode ? configuration_control[`SRPD_CFG_ALTF_BIT]
                                           : 1'b1;

    // clear acts on the rising edge that ends a low pulse
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            clear_prev <= 1'b1;
        end else begin
            clear_prev <= pattern_fault_clear;
        end
    end
    assign clear_pulse = pattern_fault_clear && !clear_prev;

    // ----------------------------------------------------------------
    // reference selection
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            tx_ref_fec_out    <= 1'b0;
            rx_ref_fec_out    <= 1'b0;
            ref_half_rate_out <= 1'b0;
            rx_ref_local_out  <= 1'b1;
            loop_timing_out   <= 1'b0;
        end else begin
            tx_ref_fec_out    <= ref_rate_select[1];
            rx_ref_fec_out    <= ref_rate_select[0];
            ref_half_rate_out <= !alt_ref_freq_select;
            rx_ref_local_out  <= signal_lost_in || lock_lost_in;
            loop_timing_out   <= host_mode && parallel_remote_loopback &&
                                 configuration_control[`SRPD_CFG_LTIME_BIT];
        end
    end

    // ----------------------------------------------------------------
    // receive deserializer
    // ----------------------------------------------------------------
    srpd_word_t rx_shift;
    logic [3:0] rx_bit_cnt;
    srpd_word_t rx_word;
    logic       rx_word_valid;
    logic       buf_in_ready;
    srpd_word_t buf_data;
    logic       buf_valid;
    logic       out_take;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            rx_shift      <= 16'h0000;
            rx_bit_cnt    <= 4'h0;
            rx_word       <= 16'h0000;
            rx_word_valid <= 1'b0;
        end else begin
            rx_shift   <= {rx_shift[14:0], rx_serial_in};
            rx_bit_cnt <= 4'(rx_bit_cnt + 4'h1);
            if (rx_bit_cnt == 4'hF) begin
                rx_word       <= {rx_shift[14:0], rx_serial_in};
                rx_word_valid <= 1'b1;
            end else if (buf_in_ready) begin
                rx_word_valid <= 1'b0;
            end
        end
    end

    // a word not taken before the next is built is overwritten; buffer absorbs stalls
    srpd_buf u_rx_buf (
        .sys_clk_in    (sys_clk_in),
        .sys_rst_in    (sys_rst_in),
        .in_valid_in   (rx_word_valid),
        .in_ready_out  (buf_in_ready),
        .in_data_in    (rx_word),
        .out_valid_out (buf_valid),
        .out_ready_in  (out_take),
        .out_data_out  (buf_data)
    );

    assign out_take = buf_valid && (!rx_parallel_valid_out || rx_parallel_ready_in);

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            rx_parallel_out       <= 16'h0000;
            rx_parallel_valid_out <= 1'b0;
        end else if (out_take) begin
            rx_parallel_out       <= buf_data;
            rx_parallel_valid_out <= 1'b1;
        end else if (rx_parallel_ready_in) begin
            rx_parallel_valid_out <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // prbs generator
    // ----------------------------------------------------------------
    logic [22:0] gen_lfsr;
    logic        gen_bit;

    assign gen_bit = gen_lfsr[`SRPD_PRBS_LEN-1] ^ gen_lfsr[`SRPD_PRBS_TAP-1];

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || !pattern_gen_enable) begin
            gen_lfsr <= `SRPD_PRBS_SEED;
        end else begin
            gen_lfsr <= {gen_lfsr[21:0], gen_bit};
        end
    end

    // ----------------------------------------------------------------
    // transmit serializer and latency line
    // ----------------------------------------------------------------
    srpd_word_t tx_shift;
    logic [3:0] tx_bit_cnt;
    logic [17:0] tx_delay;
    logic       tx_bit;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            tx_shift   <= 16'h0000;
            tx_bit_cnt <= 4'h0;
        end else begin
            tx_bit_cnt <= 4'(tx_bit_cnt + 4'h1);
            if (tx_bit_cnt == 4'hF) begin
                tx_shift <= tx_parallel_in;
            end else begin
                tx_shift <= {tx_shift[14:0], 1'b0};
            end
        end
    end

    // prbs replaces the data bit; loopback off while prbs runs
    always_comb begin
        if (pattern_gen_enable) begin
            tx_bit = gen_bit;
        end else if (serial_remote_loopback) begin
            tx_bit = rx_serial_in;
        end else begin
            tx_bit = tx_shift[15];
        end
    end

    // fixed pipe gives 18 + 1 register = 19 cycles, inside the 18..20 window
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            tx_delay      <= 18'h00000;
            tx_serial_out <= 1'b0;
        end else begin
            tx_delay      <= {tx_delay[16:0], tx_bit};
            tx_serial_out <= tx_delay[17];
        end
    end

    // ----------------------------------------------------------------
    // prbs checker
    // ----------------------------------------------------------------
    srpd_chk_t   chk_state;
    logic [22:0] chk_lfsr;
    logic [3:0]  chk_good;
    logic        chk_pred;

    assign chk_pred = chk_lfsr[`SRPD_PRBS_LEN-1] ^ chk_lfsr[`SRPD_PRBS_TAP-1];

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            chk_state <= SRPD_CHK_IDLE;
            chk_lfsr  <= 23'h000000;
            chk_good  <= 4'h0;
        end else begin
            chk_lfsr <= {chk_lfsr[21:0], rx_serial_in};                 // self-seeding
            case (chk_state)
                SRPD_CHK_IDLE: begin
                    chk_good <= 4'h0;
                    if (pattern_gen_enable) begin
                        chk_state <= SRPD_CHK_HUNT;
                    end
                end
                SRPD_CHK_HUNT: begin
                    // all-zero line predicts itself forever: no lock on it
                    if (!pattern_gen_enable) begin
                        chk_state <= SRPD_CHK_IDLE;
                    end else if (clear_pulse || chk_lfsr == '0 || chk_pred != rx_serial_in) begin
                        chk_good <= 4'h0;
                    end else if (chk_good == `SRPD_SYNC_GOOD) begin
                        chk_state <= SRPD_CHK_LOCK;
                    end else begin
                        chk_good <= 4'(chk_good + 4'h1);
                    end
                end
                SRPD_CHK_LOCK: begin
                    if (!pattern_gen_enable) begin
                        chk_state <= SRPD_CHK_IDLE;
                    end else if (clear_pulse || chk_pred != rx_serial_in) begin
                        chk_good  <= 4'h0;
                        chk_state <= SRPD_CHK_HUNT;
                    end
                end
                default: begin
                    chk_state <= SRPD_CHK_IDLE;
                end
            endcase
        end
    end

    // flag is 1 unless locked; an error while locked latches until the clear pulse
    logic fault_latched;
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            fault_latched <= 1'b0;
        end else if (chk_state == SRPD_CHK_LOCK && chk_pred != rx_serial_in) begin
            fault_latched <= 1'b1;                                      // set wins over clear
        end else if (clear_pulse) begin
            fault_latched <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            pattern_fault_flag_out <= 1'b1;
        end else begin
            pattern_fault_flag_out <= (chk_state != SRPD_CHK_LOCK) || fault_latched;
        end
    end
endmodule : srpd_top
`default_nettype wire

// [srpd_top_asserts.sv]
// Purpose: port-level checker for srpd_top
// Assumes: one clock, synchronous active-high reset
// Notes:   bound onto every srpd_top
`timescale 1ns/1ns
`default_nettype none
`include "srpd_map.svh"
module srpd_top_asserts
    import srpd_pkg::*;
(
    input wire logic       sys_clk_in,
    input wire logic       sys_rst_in,
    input wire logic       control_source_select_in,
    input wire logic       reg_wr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic [1:0] strap_ref_rate_select_in,
    input wire logic       strap_pattern_gen_enable_in,
    input wire logic       signal_lost_in,
    input wire logic       lock_lost_in,
    input wire srpd_word_t rx_parallel_out,
    input wire logic       rx_parallel_valid_out,
    input wire logic       rx_parallel_ready_in,
    input wire logic       tx_ref_fec_out,
    input wire logic       rx_ref_fec_out,
    input wire logic       ref_half_rate_out,
    input wire logic       rx_ref_local_out,
    input wire logic       loop_timing_out,
    input wire logic       pattern_fault_flag_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    sequence s_wr;
        control_source_select_in && reg_wr_in && reg_addr_in == `SRPD_CFG_OFFSET;
    endsequence
    sequence s_hold;
        !reg_wr_in && reg_addr_in == `SRPD_CFG_OFFSET;
    endsequence
    property p_write;
        s_wr ##1 s_hold |=> reg_rdata_out == $past(reg_wdata_in, 2);
    endproperty
    property p_rdata_zero;
        reg_addr_in != `SRPD_CFG_OFFSET |=> reg_rdata_out == 8'h00;
    endproperty
    property p_tx_ref;
        !control_source_select_in |=> tx_ref_fec_out == $past(strap_ref_rate_select_in[1]);
    endproperty
    property p_rx_ref;
        !control_source_select_in |=> rx_ref_fec_out == $past(strap_ref_rate_select_in[0]);
    endproperty
    property p_half;
        !control_source_select_in |=> !ref_half_rate_out;
    endproperty
    property p_ltime;
        !control_source_select_in |=> !loop_timing_out;
    endproperty
    property p_local;
        (signal_lost_in || lock_lost_in) |=> rx_ref_local_out;
    endproperty
    // checker off means never in sync
    property p_flag_idle;
        (!control_source_select_in && !strap_pattern_gen_enable_in) [*2] |=> pattern_fault_flag_out;
    endproperty
    property p_rx_hold;
        rx_parallel_valid_out && !rx_parallel_ready_in |=> rx_parallel_valid_out && $stable(rx_parallel_out);
    endproperty
    a_write: assert property (p_write) else $error("config write not read back");
    a_rdata_zero: assert property (p_rdata_zero) else $error("unmapped read not zero");
    a_tx_ref: assert property (p_tx_ref) else $error("tx ref not from strap");
    a_rx_ref: assert property (p_rx_ref) else $error("rx ref not from strap");
    a_half: assert property (p_half) else $error("half rate outside host mode");
    a_ltime: assert property (p_ltime) else $error("loop timing outside host mode");
    a_local: assert property (p_local) else $error("local reference not used");
    a_flag_idle: assert property (p_flag_idle) else $error("flag low while idle");
    a_rx_hold: assert property (p_rx_hold) else $error("rx word dropped in stall");
endmodule : srpd_top_asserts
bind srpd_top srpd_top_asserts i_srpd_top_asserts (.*);
`default_nettype wire

// [srpd_far_end.sv]
// Purpose: framer and optics stand-in on the serial side
// Assumes: word boundaries counted from reset, as the receiver does
// Notes:   loop mode echoes tx one cycle late, flip corrupts it
`timescale 1ns/1ns
`default_nettype none
module srpd_far_end (
    input  wire logic sys_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic tx_serial_in,
    input  wire logic loop_in,
    input  wire logic flip_in,
    input  wire logic stall_in,
    output logic      rx_serial_out,
    output logic      ready_out
);
    logic [3:0]  bit_cnt;
    logic [7:0]  word_cnt;
    logic [15:0] cur;
    logic        echo;
    assign ready_out = !stall_in;
    always_ff @(posedge sys_clk_in) begin
        echo <= tx_serial_in;
        if (sys_rst_in) begin
            bit_cnt <= 4'h0;
            word_cnt <= 8'h01;
            cur <= 16'h00FF;
        end else begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'hF) begin
                cur <= {word_cnt, ~word_cnt};
                word_cnt <= word_cnt + 8'h01;
            end
        end
    end
    // msb first within each word
    assign rx_serial_out = loop_in ? (echo ^ flip_in) : cur[4'hF - bit_cnt];
endmodule : srpd_far_end
`default_nettype wire

// [test_srpd_top.sv]
// Purpose: self-checking bench for srpd_top
// Assumes: bench drives on the falling edge
// Notes:   rx words from far end are {n, ~n}
`timescale 1ns/1ns
`default_nettype none
module test_srpd_top;
    import srpd_pkg::*;
    logic sys_clk_in, sys_rst_in, control_source_select_in, reg_wr_in;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic [1:0] strap_ref_rate_select_in;
    logic strap_pattern_gen_enable_in, strap_pattern_fault_clear_in;
    logic strap_serial_remote_loopback_in, strap_parallel_remote_loopback_in;
    logic signal_lost_in, lock_lost_in, tx_serial_out, rx_serial_in;
    logic rx_parallel_valid_out, rx_parallel_ready_in, tx_ref_fec_out, rx_ref_fec_out;
    logic ref_half_rate_out, rx_ref_local_out, loop_timing_out, pattern_fault_flag_out;
    logic loop_en, flip, stall;
    srpd_word_t tx_parallel_in, rx_parallel_out, w;
    logic [31:0] hist;
    int n_errors, n_compared, cyc, k, ld, ones;
    srpd_top i_srpd_top (.*);
    srpd_far_end i_srpd_far_end (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .tx_serial_in(tx_serial_out), .loop_in(loop_en), .flip_in(flip),
        .stall_in(stall), .rx_serial_out(rx_serial_in), .ready_out(rx_parallel_ready_in));
    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task automatic finish_test;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic cyc_n(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : cyc_n
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        cyc_n(1);
        reg_wr_in = 1'b0;
        reg_addr_in = 8'h07;
        cyc_n(2);
    endtask : wr_reg
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        reg_addr_in = a;
        cyc_n(2);
        chk("config", 16'(reg_rdata_out), 16'(exp));
    endtask : chk_reg
    task automatic wait_flag(input logic v);
        k = 0;
        while (pattern_fault_flag_out !== v && k < 400) begin
            ones += int'(tx_serial_out === 1'b1);
            cyc_n(1);
            k++;
        end
    endtask : wait_flag
    // ------------------------------------------------
    // clock, timeout, sequence
    // ------------------------------------------------
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        if (!sys_rst_in) cyc++;
        if (cyc == 6000) begin
            n_errors++;
            finish_test();
        end
    end
    initial begin
        {control_source_select_in, reg_wr_in, reg_wdata_in, strap_ref_rate_select_in} = '0;
        {strap_pattern_gen_enable_in, strap_serial_remote_loopback_in} = '0;
        {strap_parallel_remote_loopback_in, signal_lost_in, lock_lost_in} = '0;
        {tx_parallel_in, loop_en, flip, stall, n_errors, n_compared, cyc, ones} = '0;
        strap_pattern_fault_clear_in = 1'b1;
        reg_addr_in = 8'h07;
        sys_rst_in = 1'b1;
        cyc_n(6);
        sys_rst_in = 1'b0;
        chk("fault flag", 16'(pattern_fault_flag_out), 16'h0001);
        for (int n = 0; n < 6; n++) begin
            stall = (n == 2);
            cyc_n(stall ? 20 : 0);
            stall = 1'b0;
            k = 0;
            while (rx_parallel_valid_out !== 1'b1 && k < 40) begin
                cyc_n(1);
                k++;
            end
            chk("rx word", rx_parallel_out, {n[7:0], ~n[7:0]});
            cyc_n(1);
        end
        while (cyc % 16 != 8) cyc_n(1);
        ld = cyc + 8;
        tx_parallel_in = 16'hA5C3;
        cyc_n(16);
        tx_parallel_in = 16'h0000;
        k = 0;
        while (tx_serial_out !== 1'b1 && k < 40) begin
            cyc_n(1);
            k++;
        end
        chk("tx latency", 16'(cyc - ld >= 18 && cyc - ld <= 20), 16'h0001);
        for (int b = 15; b >= 0; b--) begin
            w[b] = tx_serial_out;
            cyc_n(1);
        end
        chk("tx word", w, 16'hA5C3);
        chk_reg(8'h07, 8'h20);
        wr_reg(8'h07, 8'h03);
        chk_reg(8'h07, 8'h20);
        for (int c = 0; c < 8; c++) begin
            control_source_select_in = c[2];
            strap_ref_rate_select_in = c[2] ? ~c[1:0] : c[1:0];
            wr_reg(8'h07, {6'h08, c[2] ? c[1:0] : ~c[1:0]});
            chk("tx ref", 16'(tx_ref_fec_out), 16'(c[1]));
            chk("rx ref", 16'(rx_ref_fec_out), 16'(c[0]));
        end
        wr_reg(8'h07, 8'h00);
        chk("half rate", 16'(ref_half_rate_out), 16'h0001);
        chk_reg(8'h08, 8'h00);
        wr_reg(8'h08, 8'hE0);
        chk_reg(8'h07, 8'h00);
        wr_reg(8'h07, 8'hE0);
        chk("loop timing", 16'(loop_timing_out), 16'h0001);
        wr_reg(8'h07, 8'hA0);
        chk("loop timing", 16'(loop_timing_out), 16'h0000);
        control_source_select_in = 1'b0;
        strap_parallel_remote_loopback_in = 1'b1;
        cyc_n(2);
        chk("half rate", 16'(ref_half_rate_out), 16'h0000);
        chk("loop timing", 16'(loop_timing_out), 16'h0000);
        for (int c = 3; c >= 0; c--) begin
            {lock_lost_in, signal_lost_in} = c[1:0];
            cyc_n(2);
            chk("local ref", 16'(rx_ref_local_out), 16'(c != 0));
        end
        // far end still sends words: tx must repeat rx 19 cycles later
        strap_serial_remote_loopback_in = 1'b1;
        k = 0;
        for (int i = 0; i < 40; i++) begin
            if (i > 18 && tx_serial_out !== hist[18]) k++;
            hist = {hist[30:0], rx_serial_in};
            cyc_n(1);
        end
        chk("serial loop", 16'(k), 16'h0000);
        strap_serial_remote_loopback_in = 1'b0;
        loop_en = 1'b1;
        // flush the echo ring so the checker starts from a quiet zero line
        cyc_n(50);
        // serial loopback request too: prbs must still win
        {strap_pattern_gen_enable_in, strap_serial_remote_loopback_in, loop_en} = 3'h7;
        wait_flag(1'b0);
        chk("fault flag", 16'(pattern_fault_flag_out), 16'h0000);
        chk("prbs active", 16'(ones > 0), 16'h0001);
        flip = 1'b1;
        cyc_n(1);
        flip = 1'b0;
        cyc_n(40);
        chk("fault flag", 16'(pattern_fault_flag_out), 16'h0001);
        strap_pattern_fault_clear_in = 1'b0;
        cyc_n(2);
        strap_pattern_fault_clear_in = 1'b1;
        wait_flag(1'b0);
        chk("fault flag", 16'(pattern_fault_flag_out), 16'h0000);
        strap_pattern_gen_enable_in = 1'b0;
        cyc_n(4);
        chk("fault flag", 16'(pattern_fault_flag_out), 16'h0001);
        finish_test();
    end
endmodule : test_srpd_top
`default_nettype wire
